// ### src/io_mux_pkg.sv
package io_mux_pkg;

  localparam int unsigned NUM_LINES       = 7;
  localparam int unsigned ADC_W           = 10;
  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned SERVO_US        = 120;
  localparam int unsigned SERVO_CYCLES    = SERVO_US * CLK_MHZ;
  localparam int unsigned AVG_WINDOW_US   = 5000;
  // The window is a whole number of servo cycles; 5000 / 120 rounds down.
  localparam int unsigned AVG_DEPTH       = AVG_WINDOW_US / SERVO_US;
  localparam int unsigned AVG_SUM_W       = 16;
  localparam int unsigned HS_PULSE_NS     = 1000;
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned HS_MIN_CYCLES   = HS_PULSE_NS / CLK_PERIOD_NS;
  localparam int unsigned FILT_W          = 8;

  // Line indices, zero based: line one is index 0.
  localparam int unsigned LINE_1          = 0;
  localparam int unsigned LINE_2          = 1;
  localparam int unsigned LINE_3          = 2;
  localparam int unsigned LINE_4          = 3;
  localparam int unsigned LINE_5          = 4;
  localparam int unsigned LINE_6          = 5;
  localparam int unsigned LINE_7          = 6;

  localparam logic [6:0] ANALOG_OK_MASK   = 7'h78;
  localparam logic [6:0] KILL_OK_MASK     = 7'h07;
  localparam logic [6:0] RAW_ENC_MASK     = 7'h07;
  localparam logic [6:0] SCALED_ENC_MASK  = 7'h60;
  localparam logic [6:0] EXT_ENC_MASK     = 7'h18;
  localparam logic [6:0] ALL_INPUT_RESET  = 7'h7F;

  typedef enum logic [2:0] {
    FN_INPUT      = 3'h0,
    FN_OUTPUT     = 3'h1,
    FN_ANALOG     = 3'h2,
    FN_KILL       = 3'h3,
    FN_RAW_ENC    = 3'h4,
    FN_SCALED_ENC = 3'h5,
    FN_EXT_ENC    = 3'h6
  } line_fn_t;

  typedef enum logic [1:0] {
    FMT_STEP_DIR  = 2'h0,
    FMT_QUAD      = 2'h1,
    FMT_UP_DOWN   = 2'h2
  } sig_fmt_t;

  typedef enum logic [1:0] {
    OP_NONE                  = 2'h0,
    OP_WAIT_ON_LINE_STATE    = 2'h1,
    OP_BRANCH_ON_INPUT       = 2'h2
  } flow_op_t;

  typedef enum logic [1:0] {
    WAIT_IDLE  = 2'h0,
    WAIT_BUSY  = 2'h1
  } wait_state_t;

endpackage : io_mux_pkg

// ### src/line_debounce.sv
`timescale 1ns/100ps
module line_debounce
  import io_mux_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              tick_i,
  input  wire logic [FILT_W-1:0] filt_cycles_i,
  input  wire logic              raw_i,
  output logic                   level_o
);

  logic              level_q;
  logic              level_d;
  logic [FILT_W-1:0] cnt_q;
  logic [FILT_W-1:0] cnt_d;

  // A change is only taken once it has stood for the filter count of ticks.
  always_comb begin
    level_d = level_q;
    cnt_d   = cnt_q;
    if (raw_i == level_q) begin
      cnt_d = '0;
    end else if (tick_i) begin
      if (cnt_q >= filt_cycles_i) begin
        level_d = raw_i;
        cnt_d   = '0;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_q <= 1'b1;
      cnt_q   <= '0;
    end else begin
      level_q <= level_d;
      cnt_q   <= cnt_d;
    end
  end

  assign level_o = level_q;

endmodule : line_debounce

// ### src/io_line_function_mux.sv
`timescale 1ns/100ps
// Function
// - Analog function only on lines four to seven
// - Ten-bit unsigned analog code per line
// - Analog value is a 41 servo cycle (4920 us) average
// - Averaged value refreshed each servo cycle
// - Raw, scaled and external encoder functions
// - High-speed line serves no other function
// - High-speed logic handles one pulse per microsecond
// - Step/direction, quadrature and up/down formats
// - Kill input only on lines one to three
// - Raw encoder output drives lines one to three
// - Scaled encoder output on lines six, seven
// - Line pairs carry the configured signal format
// - Wait stalls until line reaches chosen level
// - Wait accepts any line configured as input
// - Branch when tested inputs hold, else fall through
// - All lines are inputs after reset
// - Input change needs programmed stable servo cycles
module io_line_function_mux
  import io_mux_pkg::*;
(
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic [6:0]           line_in_i,
  output logic      [6:0]           line_out_o,
  output logic      [6:0]           line_oe_n_o,
  input  wire logic                 cfg_valid_i,
  input  wire logic [2:0]           cfg_line_i,
  input  wire line_fn_t             cfg_fn_i,
  input  wire logic                 cfg_out_level_i,
  output logic                      cfg_refused_o,
  output logic                      cfg_conflict_o,
  input  wire sig_fmt_t             hs_fmt_i,
  input  wire logic                 raw_enc_a_i,
  input  wire logic                 raw_enc_b_i,
  input  wire logic                 raw_enc_index_i,
  input  wire logic                 scaled_step_i,
  input  wire logic                 scaled_dir_i,
  output logic                      ext_step_o,
  output logic                      ext_up_o,
  output logic                      kill_o,
  input  wire logic [6:0]           kill_level_i,
  input  wire logic [FILT_W-1:0]    filt_cycles_i,
  input  wire logic [4*ADC_W-1:0]   adc_sample_i,
  output logic      [4*ADC_W-1:0]   analog_avg_o,
  output logic                      analog_upd_o,
  input  wire flow_op_t             op_i,
  input  wire logic                 op_valid_i,
  input  wire logic [2:0]           op_line_i,
  input  wire logic                 op_level_i,
  input  wire logic [6:0]           op_mask_i,
  input  wire logic [6:0]           op_value_i,
  output logic                      op_done_o,
  output logic                      op_take_branch_o,
  output logic                      op_refused_o,
  output logic                      stall_o
);

  // Ownership record, one function per line.
  line_fn_t    fn_q [NUM_LINES];
  line_fn_t    fn_d [NUM_LINES];
  logic [6:0]  out_lvl_q;
  logic [6:0]  out_lvl_d;
  logic        refused_q;
  logic        refused_d;
  logic        conflict_q;
  logic        conflict_d;
  logic [6:0]  line_bit;
  logic [6:0]  allowed_mask;
  logic [6:0]  target_mask;
  logic        busy_hit;

  always_comb begin
    line_bit     = 7'h01 << cfg_line_i;
    allowed_mask = 7'h7F;
    target_mask  = line_bit;
    unique case (cfg_fn_i)
      FN_ANALOG:     allowed_mask = ANALOG_OK_MASK;
      FN_KILL:       allowed_mask = KILL_OK_MASK;
      FN_RAW_ENC:    target_mask  = RAW_ENC_MASK;
      FN_SCALED_ENC: target_mask  = SCALED_ENC_MASK;
      FN_EXT_ENC:    target_mask  = EXT_ENC_MASK;
      default:       allowed_mask = 7'h7F;
    endcase
    busy_hit = 1'b0;
    for (int i = 0; i < NUM_LINES; i++) begin
      // A line is taken if it already holds a function other than input and other than the one requested.
      if (target_mask[i] && fn_q[i] != FN_INPUT && fn_q[i] != cfg_fn_i) begin
        busy_hit = 1'b1;
      end
    end
  end

  always_comb begin
    fn_d       = fn_q;
    out_lvl_d  = out_lvl_q;
    refused_d  = 1'b0;
    conflict_d = 1'b0;
    if (cfg_valid_i) begin
      if (cfg_line_i >= 3'(NUM_LINES) || (line_bit & allowed_mask) == '0) begin
        refused_d = 1'b1;
      end else if (busy_hit && cfg_fn_i != FN_INPUT) begin
        // Existing non-input ownership is kept; the request is rejected.
        conflict_d = 1'b1;
      end else begin
        for (int i = 0; i < NUM_LINES; i++) begin
          if (target_mask[i]) begin
            fn_d[i] = cfg_fn_i;
          end
        end
        if (cfg_fn_i == FN_OUTPUT) begin
          out_lvl_d[cfg_line_i] = cfg_out_level_i;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NUM_LINES; i++) begin
        fn_q[i] <= FN_INPUT;
      end
      out_lvl_q  <= '0;
      refused_q  <= 1'b0;
      conflict_q <= 1'b0;
    end else begin
      fn_q       <= fn_d;
      out_lvl_q  <= out_lvl_d;
      refused_q  <= refused_d;
      conflict_q <= conflict_d;
    end
  end

  // Servo tick generator.
  logic [15:0] tick_cnt_q;
  logic [15:0] tick_cnt_d;
  logic        tick;

  always_comb begin
    tick       = (tick_cnt_q == 16'(SERVO_CYCLES - 1));
    tick_cnt_d = tick ? 16'h0000 : tick_cnt_q + 16'h0001;
  end

  // Debounced digital inputs.
  logic [6:0] filt_lvl;

  for (genvar g = 0; g < NUM_LINES; g++) begin : g_filt
    line_debounce u_filt (
      .core_clk_i    (core_clk_i),
      .rst_n_i       (rst_n_i),
      .tick_i        (tick),
      .filt_cycles_i (filt_cycles_i),
      .raw_i         (line_in_i[g]),
      .level_o       (filt_lvl[g])
    );
  end

  // Moving average: a ring of samples and a running sum per channel.
  logic [ADC_W-1:0]     ring_q [4][AVG_DEPTH];
  logic [ADC_W-1:0]     ring_d [4][AVG_DEPTH];
  logic [AVG_SUM_W-1:0] sum_q  [4];
  logic [AVG_SUM_W-1:0] sum_d  [4];
  logic [5:0]           wr_q;
  logic [5:0]           wr_d;
  logic [4*ADC_W-1:0]   avg_q;
  logic [4*ADC_W-1:0]   avg_d;
  logic                 upd_q;
  logic                 upd_d;

  always_comb begin
    ring_d = ring_q;
    sum_d  = sum_q;
    wr_d   = wr_q;
    avg_d  = avg_q;
    upd_d  = 1'b0;
    if (tick) begin
      for (int c = 0; c < 4; c++) begin
        // Sample taken as a 10-bit unsigned code.
        ring_d[c][wr_q] = adc_sample_i[c*ADC_W +: ADC_W];
        sum_d[c] = sum_q[c] - AVG_SUM_W'(ring_q[c][wr_q])
                 + AVG_SUM_W'(adc_sample_i[c*ADC_W +: ADC_W]);
        avg_d[c*ADC_W +: ADC_W] = ADC_W'(sum_d[c] / AVG_SUM_W'(AVG_DEPTH));
      end
      wr_d  = (wr_q == 6'(AVG_DEPTH - 1)) ? 6'h00 : wr_q + 6'h01;
      upd_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int c = 0; c < 4; c++) begin
        for (int k = 0; k < AVG_DEPTH; k++) begin
          ring_q[c][k] <= '0;
        end
        sum_q[c] <= '0;
      end
      wr_q       <= '0;
      avg_q      <= '0;
      upd_q      <= 1'b0;
      tick_cnt_q <= '0;
    end else begin
      ring_q     <= ring_d;
      sum_q      <= sum_d;
      wr_q       <= wr_d;
      avg_q      <= avg_d;
      upd_q      <= upd_d;
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // Pin drive, high-speed decode and kill.
  logic [6:0] pin_out_d;
  logic [6:0] pin_oe_n_d;
  logic [6:0] pin_out_q;
  logic [6:0] pin_oe_n_q;
  logic       ext_step_d;
  logic       ext_up_d;
  logic       ext_step_q;
  logic       ext_up_q;
  logic       ext_a_q;
  logic       ext_b_q;
  logic       kill_d;
  logic       kill_q;

  always_comb begin
    pin_out_d  = out_lvl_q;
    pin_oe_n_d = 7'h7F;
    ext_step_d = 1'b0;
    ext_up_d   = ext_up_q;
    kill_d     = 1'b0;
    for (int i = 0; i < NUM_LINES; i++) begin
      if (fn_q[i] == FN_OUTPUT) begin
        pin_oe_n_d[i] = 1'b0;
      end
      if (fn_q[i] == FN_KILL && filt_lvl[i] == kill_level_i[i]) begin
        kill_d = 1'b1;
      end
    end
    if (fn_q[LINE_1] == FN_RAW_ENC) begin
      pin_out_d[2:0]  = {raw_enc_index_i, raw_enc_b_i, raw_enc_a_i};
      pin_oe_n_d[2:0] = 3'h0;
    end
    if (fn_q[LINE_6] == FN_SCALED_ENC) begin
      pin_oe_n_d[6:5] = 2'h0;
      unique case (hs_fmt_i)
        FMT_QUAD:    pin_out_d[6:5] = {scaled_step_i ^ scaled_dir_i,
                                       scaled_step_i};
        FMT_UP_DOWN: pin_out_d[6:5] = {scaled_step_i & ~scaled_dir_i,
                                       scaled_step_i & scaled_dir_i};
        default:     pin_out_d[6:5] = {scaled_dir_i, scaled_step_i};
      endcase
    end
    if (fn_q[LINE_4] == FN_EXT_ENC) begin
      // Per-clock sampling at 4 ns resolves 1 MHz pulses easily.
      unique case (hs_fmt_i)
        FMT_QUAD: begin
          if ((ext_a_q ^ line_in_i[LINE_4]) | (ext_b_q ^ line_in_i[LINE_5]))
          begin
            ext_step_d = 1'b1;
            ext_up_d   = ext_a_q ^ line_in_i[LINE_5];
          end
        end
        FMT_UP_DOWN: begin
          if (line_in_i[LINE_4] & ~ext_a_q) begin
            ext_step_d = 1'b1;
            ext_up_d   = 1'b1;
          end else if (line_in_i[LINE_5] & ~ext_b_q) begin
            ext_step_d = 1'b1;
            ext_up_d   = 1'b0;
          end
        end
        default: begin
          if (line_in_i[LINE_4] & ~ext_a_q) begin
            ext_step_d = 1'b1;
            ext_up_d   = line_in_i[LINE_5];
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_out_q  <= '0;
      pin_oe_n_q <= 7'h7F;
      ext_step_q <= 1'b0;
      ext_up_q   <= 1'b0;
      ext_a_q    <= 1'b0;
      ext_b_q    <= 1'b0;
      kill_q     <= 1'b0;
    end else begin
      pin_out_q  <= pin_out_d;
      pin_oe_n_q <= pin_oe_n_d;
      ext_step_q <= ext_step_d;
      ext_up_q   <= ext_up_d;
      ext_a_q    <= line_in_i[LINE_4];
      ext_b_q    <= line_in_i[LINE_5];
      kill_q     <= kill_d;
    end
  end

  // Program flow: wait on line state and branch on inputs.
  wait_state_t wst_q;
  wait_state_t wst_d;
  logic [2:0]  wline_q;
  logic [2:0]  wline_d;
  logic        wlvl_q;
  logic        wlvl_d;
  logic        done_d;
  logic        done_q;
  logic        br_d;
  logic        br_q;
  logic        oref_d;
  logic        oref_q;
  logic [6:0]  is_input;

  always_comb begin
    for (int i = 0; i < NUM_LINES; i++) begin
      is_input[i] = (fn_q[i] == FN_INPUT || fn_q[i] == FN_KILL);
    end
    wst_d   = wst_q;
    wline_d = wline_q;
    wlvl_d  = wlvl_q;
    done_d  = 1'b0;
    br_d    = 1'b0;
    oref_d  = 1'b0;
    unique case (wst_q)
      WAIT_IDLE: begin
        if (op_valid_i && op_i == OP_WAIT_ON_LINE_STATE) begin
          if (op_line_i < 3'(NUM_LINES) && is_input[op_line_i]) begin
            wst_d   = WAIT_BUSY;
            wline_d = op_line_i;
            wlvl_d  = op_level_i;
          end else begin
            oref_d = 1'b1;
          end
        end else if (op_valid_i && op_i == OP_BRANCH_ON_INPUT) begin
          done_d = 1'b1;
          br_d   = ((filt_lvl & op_mask_i) == (op_value_i & op_mask_i))
                 && ((op_mask_i & ~is_input) == '0);
        end
      end
      WAIT_BUSY: begin
        if (filt_lvl[wline_q] == wlvl_q) begin
          wst_d  = WAIT_IDLE;
          done_d = 1'b1;
        end
      end
      default: wst_d = WAIT_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wst_q   <= WAIT_IDLE;
      wline_q <= '0;
      wlvl_q  <= 1'b0;
      done_q  <= 1'b0;
      br_q    <= 1'b0;
      oref_q  <= 1'b0;
    end else begin
      wst_q   <= wst_d;
      wline_q <= wline_d;
      wlvl_q  <= wlvl_d;
      done_q  <= done_d;
      br_q    <= br_d;
      oref_q  <= oref_d;
    end
  end

  assign line_out_o       = pin_out_q;
  assign line_oe_n_o      = pin_oe_n_q;
  assign cfg_refused_o    = refused_q;
  assign cfg_conflict_o   = conflict_q;
  assign ext_step_o       = ext_step_q;
  assign ext_up_o         = ext_up_q;
  assign kill_o           = kill_q;
  assign analog_avg_o     = avg_q;
  assign analog_upd_o     = upd_q;
  assign op_done_o        = done_q;
  assign op_take_branch_o = br_q;
  assign op_refused_o     = oref_q;
  assign stall_o          = (wst_q == WAIT_BUSY);

endmodule : io_line_function_mux

// ### sim/io_mux_props.sv
`timescale 1ns/100ps
module io_mux_props
  import io_mux_pkg::*;
(
  input  wire logic               core_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic [6:0]         line_in_i,
  input  wire logic [6:0]         line_oe_n_o,
  input  wire logic               cfg_valid_i,
  input  wire logic [2:0]         cfg_line_i,
  input  wire line_fn_t           cfg_fn_i,
  input  wire logic               cfg_refused_o,
  input  wire logic               cfg_conflict_o,
  input  wire logic               ext_step_o,
  input  wire logic [4*ADC_W-1:0] analog_avg_o,
  input  wire logic               analog_upd_o,
  input  wire flow_op_t           op_i,
  input  wire logic               op_valid_i,
  input  wire logic               op_done_o,
  input  wire logic               op_take_branch_o,
  input  wire logic               op_refused_o,
  input  wire logic               stall_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // The first update after reset has no reference, so spacing starts later.
  logic [15:0] gap_q;
  logic [15:0] gap_d;
  logic        seen_q;
  logic        seen_d;

  always_comb begin
    gap_d  = analog_upd_o ? 16'h0000 : gap_q + 16'h0001;
    seen_d = seen_q | analog_upd_o;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_q  <= 16'h0000;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= gap_d;
      seen_q <= seen_d;
    end
  end

  property p_oe_change;
    $changed(line_oe_n_o) |-> $past(cfg_valid_i, 2);
  endproperty
  a_oe_change: assert property (p_oe_change)
    else $error("Pin drive changed without a configuration.");
  property p_analog_refuse;
    cfg_valid_i && cfg_fn_i == FN_ANALOG && cfg_line_i < 3'h3
      |=> cfg_refused_o;
  endproperty
  a_analog_refuse: assert property (p_analog_refuse)
    else $error("Analog request on a low line was not refused.");
  property p_kill_refuse;
    cfg_valid_i && cfg_fn_i == FN_KILL && cfg_line_i inside {[3'h3:3'h6]}
      |=> cfg_refused_o;
  endproperty
  a_kill_refuse: assert property (p_kill_refuse)
    else $error("Kill request on a high line was not refused.");
  property p_upd_period;
    analog_upd_o && seen_q |-> gap_q == 16'(SERVO_CYCLES - 1);
  endproperty
  a_upd_period: assert property (p_upd_period)
    else $error("Analog update spacing is not one servo cycle.");
  property p_avg_hold;
    $changed(analog_avg_o) |-> analog_upd_o;
  endproperty
  a_avg_hold: assert property (p_avg_hold)
    else $error("Analog average changed without an update.");
  property p_wait_stall;
    op_valid_i && op_i == OP_WAIT_ON_LINE_STATE && !stall_o
      |=> stall_o || op_refused_o;
  endproperty
  a_wait_stall: assert property (p_wait_stall)
    else $error("Wait request neither stalled nor was refused.");
  property p_branch_done;
    op_valid_i && op_i == OP_BRANCH_ON_INPUT && !stall_o |=> op_done_o;
  endproperty
  a_branch_done: assert property (p_branch_done)
    else $error("Branch request was not answered.");
  property p_take_done;
    op_take_branch_o |-> op_done_o;
  endproperty
  a_take_done: assert property (p_take_done)
    else $error("Branch taken without completion.");
  property p_ext_step;
    ext_step_o |-> $past(line_in_i[4:3], 1) != $past(line_in_i[4:3], 2);
  endproperty
  a_ext_step: assert property (p_ext_step)
    else $error("Encoder count without a pin change.");
  property p_cfg_cause;
    cfg_refused_o || cfg_conflict_o
      |-> $past(cfg_valid_i) && !(cfg_refused_o && cfg_conflict_o);
  endproperty
  a_cfg_cause: assert property (p_cfg_cause)
    else $error("Configuration answer without a single request.");

  c_conflict: cover property (cfg_conflict_o);
  c_branch: cover property (op_take_branch_o);
  c_upd: cover property (analog_upd_o && seen_q);
endmodule : io_mux_props

bind io_line_function_mux io_mux_props u_props (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .line_in_i(line_in_i),
  .line_oe_n_o(line_oe_n_o), .cfg_valid_i(cfg_valid_i),
  .cfg_line_i(cfg_line_i), .cfg_fn_i(cfg_fn_i),
  .cfg_refused_o(cfg_refused_o), .cfg_conflict_o(cfg_conflict_o),
  .ext_step_o(ext_step_o), .analog_avg_o(analog_avg_o),
  .analog_upd_o(analog_upd_o), .op_i(op_i), .op_valid_i(op_valid_i),
  .op_done_o(op_done_o), .op_take_branch_o(op_take_branch_o),
  .op_refused_o(op_refused_o), .stall_o(stall_o)
);

// ### sim/line_partner.sv
`timescale 1ns/100ps
module line_partner (
  input  wire logic       core_clk_i,
  input  wire logic [6:0] line_out_i,
  input  wire logic [6:0] line_oe_n_i,
  input  wire logic [6:0] drv_i,
  input  wire logic [6:0] drv_en_i,
  output logic      [6:0] line_o
);
  // Lines four to seven have no pull-up, so a released one keeps moving.
  logic [6:0] float_q = 7'h00;

  always_ff @(posedge core_clk_i) begin
    float_q <= ~line_o;
  end

  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (!line_oe_n_i[i]) begin
        line_o[i] = line_out_i[i];
      end else if (drv_en_i[i]) begin
        line_o[i] = drv_i[i];
      end else begin
        line_o[i] = (i < 3) ? 1'b1 : float_q[i];
      end
    end
  end
endmodule : line_partner

// ### sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  import io_mux_pkg::*;
  logic core_clk, rst_n, cfg_valid, cfg_lvl, op_valid, op_lvl;
  logic raw_a, raw_b, raw_idx, ext_step, ext_up, kill, upd;
  logic cfg_ref, cfg_conf, done, take, op_ref, stall;
  logic [2:0] cfg_line, op_line;
  logic [6:0] line_in, line_out, oe_n, drv, drv_en, op_mask, op_val;
  logic [39:0] avg;
  line_fn_t cfg_fn;
  sig_fmt_t hs_fmt;
  flow_op_t op;
  int failures = 0;
  int check_count = 0;

  io_line_function_mux dut (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .line_in_i(line_in),
    .line_out_o(line_out), .line_oe_n_o(oe_n), .cfg_valid_i(cfg_valid),
    .cfg_line_i(cfg_line), .cfg_fn_i(cfg_fn), .cfg_out_level_i(cfg_lvl),
    .cfg_refused_o(cfg_ref), .cfg_conflict_o(cfg_conf), .hs_fmt_i(hs_fmt),
    .raw_enc_a_i(raw_a), .raw_enc_b_i(raw_b), .raw_enc_index_i(raw_idx),
    .scaled_step_i(1'b0), .scaled_dir_i(1'b0), .ext_step_o(ext_step),
    .ext_up_o(ext_up), .kill_o(kill), .kill_level_i(7'h00),
    .filt_cycles_i(8'h00), .adc_sample_i({4{10'h334}}),
    .analog_avg_o(avg), .analog_upd_o(upd), .op_i(op),
    .op_valid_i(op_valid), .op_line_i(op_line), .op_level_i(op_lvl),
    .op_mask_i(op_mask), .op_value_i(op_val), .op_done_o(done),
    .op_take_branch_o(take), .op_refused_o(op_ref), .stall_o(stall));
  line_partner u_partner (.core_clk_i(core_clk), .line_out_i(line_out),
    .line_oe_n_i(oe_n), .drv_i(drv), .drv_en_i(drv_en), .line_o(line_in));

  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("Checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // Answer is sampled one cycle after the request, pin drive one later.
  task automatic cfg(input logic [2:0] ln, input line_fn_t fn,
                     input logic lvl, input logic [1:0] exp);
    @(negedge core_clk);
    cfg_line = ln;
    cfg_fn = fn;
    cfg_lvl = lvl;
    cfg_valid = 1'b1;
    @(negedge core_clk);
    cfg_valid = 1'b0;
    check({cfg_ref, cfg_conf}, exp);
    @(negedge core_clk);
  endtask : cfg

  task automatic flow(input flow_op_t o, input logic [2:0] ln,
                      input logic [6:0] mask, input logic [6:0] val);
    @(negedge core_clk);
    op = o;
    op_line = ln;
    op_lvl = 1'b0;
    op_mask = mask;
    op_val = val;
    op_valid = 1'b1;
    @(negedge core_clk);
    op_valid = 1'b0;
  endtask : flow

  task automatic test_refuse;
    for (int i = 0; i < 3; i++) cfg(3'(i), FN_ANALOG, 0, 2'b10);
    for (int i = 3; i < 7; i++) cfg(3'(i), FN_KILL, 0, 2'b10);
    cfg(3'h3, FN_ANALOG, 0, 2'b00);
    cfg(3'h3, FN_INPUT, 0, 2'b00);
    check(oe_n, 7'h7F);
  endtask : test_refuse

  task automatic test_raw_output;
    cfg(3'h0, FN_RAW_ENC, 0, 2'b00);
    check({oe_n[2:0], line_out[2:0]}, 6'b000101);
    cfg(3'h1, FN_KILL, 0, 2'b01);
    for (int i = 0; i < 3; i++) cfg(3'(i), FN_INPUT, 0, 2'b00);
    cfg(3'h0, FN_OUTPUT, 1, 2'b00);
    check({oe_n, line_out[0]}, 8'hFD);
    cfg(3'h0, FN_KILL, 0, 2'b01);
    cfg(3'h0, FN_INPUT, 0, 2'b00);
    cfg(3'h6, FN_SCALED_ENC, 0, 2'b00);
    check(oe_n, 7'h1F);
    cfg(3'h5, FN_OUTPUT, 1, 2'b01);
  endtask : test_raw_output

  task automatic test_ext;
    logic [1:0] seq [8] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h2, 2'h3, 2'h1, 2'h0};
    logic [31:0] cnt [2];
    logic up [2];
    cfg(3'h3, FN_EXT_ENC, 0, 2'b00);
    drv_en[4:3] = 2'b11;
    for (int f = 0; f < 3; f++) begin
      hs_fmt = sig_fmt_t'(f);
      cnt = '{0, 0};
      for (int s = 0; s < 8; s++) begin
        drv[4:3] = seq[s];
        // Changes stay one microsecond apart, the fastest allowed.
        repeat (HS_MIN_CYCLES) begin
          @(negedge core_clk);
          cnt[s / 4] += ext_step;
        end
        up[s / 4] = ext_up;
      end
      if (hs_fmt == FMT_QUAD) begin
        check({cnt[0][7:0], cnt[1][7:0]}, {8'd4, 8'd4});
        check(up[0] ^ up[1], 1'b1);
      end else begin
        check(cnt[0] != 0, 1'b1);
      end
    end
  endtask : test_ext

  task automatic test_flow;
    logic [31:0] n;
    n = 0;
    flow(OP_WAIT_ON_LINE_STATE, 3'h5, 7'h00, 7'h00);
    check(op_ref, 1'b1);
    flow(OP_WAIT_ON_LINE_STATE, 3'h0, 7'h00, 7'h00);
    check(stall, 1'b1);
    drv_en[0] = 1'b1;
    drv[0] = 1'b0;
    repeat (10) @(negedge core_clk);
    check(stall, 1'b1);
    for (int c = 0; c < 70000 && done !== 1'b1; c++) begin
      @(negedge core_clk);
      if (upd === 1'b1) begin
        n++;
        check(avg, {4{10'(20 * n)}});
      end
    end
    check({done, n != 0}, 2'b11);
    @(negedge core_clk);
    check(stall, 1'b0);
    flow(OP_BRANCH_ON_INPUT, 3'h0, 7'h01, 7'h00);
    check({done, take}, 2'b11);
    flow(OP_BRANCH_ON_INPUT, 3'h0, 7'h01, 7'h01);
    check({done, take}, 2'b10);
    cfg(3'h0, FN_KILL, 0, 2'b00);
    check(kill, 1'b1);
  endtask : test_flow

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  initial begin
    #400000;
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    complete_run;
  end

  initial begin
    {rst_n, cfg_valid, cfg_lvl, op_valid, op_lvl} = 5'h00;
    {raw_a, raw_b, raw_idx} = 3'b101;
    {cfg_line, op_line, drv, drv_en, op_mask, op_val} = 34'h0;
    cfg_fn = FN_INPUT;
    hs_fmt = FMT_STEP_DIR;
    op = OP_NONE;
    repeat (5) @(negedge core_clk);
    rst_n = 1'b1;
    check({oe_n, line_out}, 14'h3F80);
    test_refuse;
    test_raw_output;
    test_ext;
    test_flow;
    complete_run;
  end
endmodule : testbench
